/* File: hw/aacu_pkg.sv */
// Package: command codes, status codes, field widths for the admin command unit
package aacu_pkg;
  localparam int NUM_QUEUES  = 8;
  localparam int PASID_W     = 20;
  localparam int HANDLE_W    = 8;
  localparam int NUM_HANDLES = 16;
  localparam int CMD_W       = 5;
  localparam int STATUS_W    = 8;

  typedef enum logic [CMD_W-1:0] {
    AACU_CMD_NONE       = 5'h00,
    AACU_CMD_ENABLE_DEV = 5'h01,
    AACU_CMD_DISABLE_DEV= 5'h02,
    AACU_CMD_DRAIN_ALL  = 5'h03,
    AACU_CMD_ABORT_ALL  = 5'h04,
    AACU_CMD_RESET_DEV  = 5'h05,
    AACU_CMD_ENABLE_WQ  = 5'h06,
    AACU_CMD_DISABLE_WQ = 5'h07,
    AACU_CMD_DRAIN_WQ   = 5'h08,
    AACU_CMD_ABORT_WQ   = 5'h09,
    AACU_CMD_RESET_WQ   = 5'h0a,
    AACU_CMD_DRAIN_PAS  = 5'h0b,
    AACU_CMD_ABORT_PAS  = 5'h0c,
    AACU_CMD_REQ_HANDLE = 5'h0d
  } aacu_cmd_t;

  localparam logic [STATUS_W-1:0] ST_SUCCESS     = 8'h00;
  localparam logic [STATUS_W-1:0] ST_BAD_CMD     = 8'h01;
  localparam logic [STATUS_W-1:0] ST_DEV_CFG_ERR = 8'h02;
  localparam logic [STATUS_W-1:0] ST_WQ_CFG_ERR  = 8'h03;
  localparam logic [STATUS_W-1:0] ST_DEV_NOT_EN  = 8'h04;
  localparam logic [STATUS_W-1:0] ST_NO_HANDLE   = 8'h05;
  localparam logic [STATUS_W-1:0] ST_NO_CAP      = 8'h06;
endpackage : aacu_pkg

/* File: hw/aacu_handle_mem.sv */
// Free-list of interrupt handles with registered read data
`timescale 1ns/1ps
module aacu_handle_mem
  import aacu_pkg::*;
#(
  parameter int DEPTH = NUM_HANDLES,
  parameter int AW    = $clog2(NUM_HANDLES)
) (
  input  wire logic          sys_clk,
  input  wire logic          reset,
  input  wire logic          clkEn,
  input  wire logic          allocReq,
  output logic               allocOk_q,
  output logic [AW-1:0]      allocIdx_q
);
  logic [DEPTH-1:0] used_q;
  logic [AW-1:0]    freeIdx;
  logic             anyFree;

  always_comb begin
    freeIdx = '0;
    anyFree = 1'b0;
    for (int i = DEPTH - 1; i >= 0; i--) begin
      if (!used_q[i]) begin
        freeIdx = AW'(i);
        anyFree = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      used_q     <= '0;
      allocOk_q  <= 1'b0;
      allocIdx_q <= '0;
    end else if (clkEn && allocReq) begin
      allocOk_q  <= anyFree;
      allocIdx_q <= freeIdx;
      if (anyFree) begin
        used_q[freeIdx] <= 1'b1;
      end
    end
  end
endmodule : aacu_handle_mem

/* File: hw/aacu_admin_cmd.sv */
// Administrative command interpreter: device/queue enable, drain, abort, reset, handles
`timescale 1ns/1ps
// Function
// - A command is taken only on a command write strobe; it selects the operation.
// - Completion shows in status; interrupt pulses when the request bit was set.
// - Enable device checks global configuration, enabling only when valid.
// - Disable device blocks intake, waits idle, then disables queues and device in the same cycle.
// - Enable queue checks queue configuration; intake opens only after success.
// - Disable queue blocks intake on named queues, waits, then disables them.
// - Device-wide drain/abort waits for all work; later work may start.
// - Per-queue drain/abort waits for named queues; software holds submissions.
// - Per-PASID drain/abort waits until no PASID work remains anywhere.
// - Reset device aborts, waits, disables all, restores configuration defaults.
// - Reset queue aborts, waits, disables, resets queue config except size.
// - Handle request works only with capability set; error when exhausted.
// - After drain/abort/reset completes no activity remains for covered work.
// - A drain may wait on more work than it must cover.
// - Abort lets engines finish descriptors fully or abandon them.
// - Abandoned descriptors write no completion record and raise no interrupt.
// - Started operations run on; their length is bounded by queue limits.
// - Per-PASID abort discards unprocessed descriptors of that PASID.
module aacu_admin_cmd
  import aacu_pkg::*;
#(
  parameter int NQ = NUM_QUEUES
) (
  input  wire logic                sys_clk,
  input  wire logic                reset,
  input  wire logic                clkEn,
  input  wire logic                cmdWrite,
  input  wire logic [CMD_W-1:0]    cmdCode,
  input  wire logic [NQ-1:0]       cmdQueueMask,
  input  wire logic [PASID_W-1:0]  cmdPasid,
  input  wire logic                cmdReqIntr,
  input  wire logic                devConfigValid,
  input  wire logic [NQ-1:0]       queueConfigValid,
  input  wire logic                handleReqCap,
  input  wire logic [NQ-1:0]       queueBusy,
  input  wire logic                enginesBusy,
  input  wire logic                pasidBusy,
  output logic                     devEnabled_q,
  output logic [NQ-1:0]            queueEnabled_q,
  output logic [NQ-1:0]            queueIntakeBlock_q,
  output logic                     abortReq_q,
  output logic [NQ-1:0]            abortQueueMask_q,
  output logic                     pasidMatchEn_q,
  output logic [PASID_W-1:0]       pasidMatch_q,
  output logic                     devConfigReset_q,
  output logic [NQ-1:0]            queueConfigReset_q,
  output logic                     cmdActive_q,
  output logic [STATUS_W-1:0]      cmdResult_q,
  output logic [HANDLE_W-1:0]      handle_q,
  output logic                     cmdDoneIntr_q
);
  localparam int HAW = $clog2(NUM_HANDLES);

  typedef enum logic [4:0] {
    S_IDLE   = 5'b00001,
    S_EXEC   = 5'b00010,
    S_WAIT   = 5'b00100,
    S_HANDLE = 5'b01000,
    S_DONE   = 5'b10000
  } aacu_state_t;

  aacu_state_t          state_q, state_d;
  aacu_cmd_t            cmd_q;
  logic [NQ-1:0]        mask_q;
  logic                 reqIntr_q;
  logic [STATUS_W-1:0]  result_q;
  logic                 handleReq;
  logic                 handleOk;
  logic [HAW-1:0]       handleIdx;

  function automatic logic isDrainLike(input aacu_cmd_t c);
    return c inside {AACU_CMD_DISABLE_DEV, AACU_CMD_DRAIN_ALL, AACU_CMD_ABORT_ALL,
                     AACU_CMD_RESET_DEV, AACU_CMD_DISABLE_WQ, AACU_CMD_DRAIN_WQ,
                     AACU_CMD_ABORT_WQ, AACU_CMD_RESET_WQ, AACU_CMD_DRAIN_PAS,
                     AACU_CMD_ABORT_PAS};
  endfunction : isDrainLike

  function automatic logic isAbort(input aacu_cmd_t c);
    return c inside {AACU_CMD_ABORT_ALL, AACU_CMD_RESET_DEV, AACU_CMD_ABORT_WQ,
                     AACU_CMD_RESET_WQ, AACU_CMD_ABORT_PAS};
  endfunction : isAbort

  function automatic logic isDevWide(input aacu_cmd_t c);
    return c inside {AACU_CMD_DISABLE_DEV, AACU_CMD_DRAIN_ALL, AACU_CMD_ABORT_ALL,
                     AACU_CMD_RESET_DEV};
  endfunction : isDevWide

  // Work still outstanding for the command in hand
  wire  isPasidCmd  = (cmd_q == AACU_CMD_DRAIN_PAS) || (cmd_q == AACU_CMD_ABORT_PAS);
  wire  anyQueueBusy = |queueBusy;
  wire  maskBusy    = |(queueBusy & mask_q);
  wire  workPending = isDevWide(cmd_q) ? (anyQueueBusy || enginesBusy) :
                      isPasidCmd       ? pasidBusy :
                                         maskBusy;
  wire  validCmd    = cmdCode inside {[AACU_CMD_ENABLE_DEV:AACU_CMD_REQ_HANDLE]};
  wire  takeCmd     = clkEn && cmdWrite && (state_q == S_IDLE);
  wire  inExec      = clkEn && (state_q == S_EXEC);
  wire  waitDone    = clkEn && (state_q == S_WAIT) && !workPending;
  wire  qCfgOk      = &(queueConfigValid | ~mask_q);
  wire  qAllOff     = (mask_q & queueEnabled_q) == '0;

  // Result of the non-waiting commands, decided in the execute step
  logic [STATUS_W-1:0] execResult;
  always_comb begin
    execResult = ST_SUCCESS;
    unique case (cmd_q)
      AACU_CMD_ENABLE_DEV: execResult = devConfigValid ? ST_SUCCESS : ST_DEV_CFG_ERR;
      AACU_CMD_ENABLE_WQ:  execResult = !devEnabled_q ? ST_DEV_NOT_EN :
                                        (qCfgOk ? ST_SUCCESS : ST_WQ_CFG_ERR);
      AACU_CMD_REQ_HANDLE: execResult = handleReqCap ? ST_SUCCESS : ST_NO_CAP;
      default:             execResult = ST_SUCCESS;
    endcase
  end

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      S_IDLE:   if (cmdWrite) state_d = validCmd ? S_EXEC : S_DONE;
      S_EXEC: begin
        if (isDrainLike(cmd_q)) begin
          state_d = S_WAIT;
        end else if (cmd_q == AACU_CMD_REQ_HANDLE && handleReqCap) begin
          state_d = S_HANDLE;
        end else begin
          state_d = S_DONE;
        end
      end
      S_WAIT:   if (!workPending) state_d = S_DONE;
      S_HANDLE: state_d = S_DONE;
      S_DONE:   state_d = S_IDLE;
      default:  state_d = S_IDLE;
    endcase
  end

  assign handleReq = inExec && (cmd_q == AACU_CMD_REQ_HANDLE) && handleReqCap;

  aacu_handle_mem #(
    .DEPTH (NUM_HANDLES),
    .AW    (HAW)
  ) aacu_handle_mem_i (
    .sys_clk    (sys_clk),
    .reset      (reset),
    .clkEn      (clkEn),
    .allocReq   (handleReq),
    .allocOk_q  (handleOk),
    .allocIdx_q (handleIdx)
  );

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_q <= S_IDLE;
    end else if (clkEn) begin
      state_q <= state_d;
    end
  end

  // Command capture and status
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cmd_q       <= AACU_CMD_NONE;
      mask_q      <= '0;
      reqIntr_q   <= 1'b0;
      result_q    <= ST_SUCCESS;
      cmdActive_q <= 1'b0;
      cmdResult_q <= ST_SUCCESS;
    end else if (clkEn) begin
      if (takeCmd) begin
        cmd_q       <= validCmd ? aacu_cmd_t'(cmdCode) : AACU_CMD_NONE;
        mask_q      <= cmdQueueMask;
        reqIntr_q   <= cmdReqIntr;
        result_q    <= validCmd ? ST_SUCCESS : ST_BAD_CMD;
        cmdActive_q <= 1'b1;
      end
      if (state_q == S_EXEC) result_q <= execResult;
      if (state_q == S_HANDLE && !handleOk) result_q <= ST_NO_HANDLE;
      if (state_q == S_DONE) begin
        cmdActive_q <= 1'b0;
        cmdResult_q <= result_q;
      end
    end
  end

  // Completion interrupt pulse and handle value
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cmdDoneIntr_q <= 1'b0;
      handle_q      <= '0;
    end else if (clkEn) begin
      cmdDoneIntr_q <= (state_q == S_DONE) && reqIntr_q;
      if (state_q == S_HANDLE && handleOk) handle_q <= HANDLE_W'(handleIdx);
    end
  end

  // Intake blocking and abort / PASID steering while waiting
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      queueIntakeBlock_q <= '0;
      abortReq_q         <= 1'b0;
      abortQueueMask_q   <= '0;
      pasidMatchEn_q     <= 1'b0;
      pasidMatch_q       <= '0;
    end else if (clkEn) begin
      if (takeCmd) pasidMatch_q <= cmdPasid;
      if (inExec && isDrainLike(cmd_q)) begin
        if (cmd_q inside {AACU_CMD_DISABLE_DEV, AACU_CMD_RESET_DEV}) begin
          queueIntakeBlock_q <= '1;
        end else if (cmd_q inside {AACU_CMD_DISABLE_WQ, AACU_CMD_RESET_WQ}) begin
          queueIntakeBlock_q <= queueIntakeBlock_q | mask_q;
        end
        abortReq_q       <= isAbort(cmd_q);
        abortQueueMask_q <= isDevWide(cmd_q) ? '1 : (isPasidCmd ? '0 : mask_q);
        pasidMatchEn_q   <= isPasidCmd;
      end
      if (waitDone) begin
        abortReq_q       <= 1'b0;
        abortQueueMask_q <= '0;
        pasidMatchEn_q   <= 1'b0;
        if (cmd_q inside {AACU_CMD_DISABLE_DEV, AACU_CMD_RESET_DEV}) begin
          queueIntakeBlock_q <= '0;
        end else if (cmd_q inside {AACU_CMD_DISABLE_WQ, AACU_CMD_RESET_WQ}) begin
          queueIntakeBlock_q <= queueIntakeBlock_q & ~mask_q;
        end
      end
    end
  end

  // Device and queue enables, configuration reset pulses
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      devEnabled_q       <= 1'b0;
      queueEnabled_q     <= '0;
      devConfigReset_q   <= 1'b0;
      queueConfigReset_q <= '0;
    end else if (clkEn) begin
      devConfigReset_q   <= 1'b0;
      queueConfigReset_q <= '0;
      if (inExec && cmd_q == AACU_CMD_ENABLE_DEV && devConfigValid) begin
        devEnabled_q <= 1'b1;
      end
      if (inExec && cmd_q == AACU_CMD_ENABLE_WQ && devEnabled_q && qCfgOk) begin
        queueEnabled_q <= queueEnabled_q | mask_q;
      end
      if (waitDone) begin
        unique case (cmd_q)
          AACU_CMD_DISABLE_DEV: begin
            queueEnabled_q <= '0;
            devEnabled_q   <= 1'b0;
          end
          AACU_CMD_RESET_DEV: begin
            queueEnabled_q   <= '0;
            devEnabled_q     <= 1'b0;
            devConfigReset_q <= 1'b1;
          end
          AACU_CMD_DISABLE_WQ: queueEnabled_q <= queueEnabled_q & ~mask_q;
          AACU_CMD_RESET_WQ: begin
            queueEnabled_q     <= queueEnabled_q & ~mask_q;
            queueConfigReset_q <= mask_q;
          end
          default: ;
        endcase
      end
    end
  end

  // Assertions
  property p_intr_on_done;
    @(posedge sys_clk) disable iff (reset)
    (clkEn && state_q == S_DONE && reqIntr_q) |=> cmdDoneIntr_q;
  endproperty
  intr_on_done_a: assert property (p_intr_on_done)
    else $error("completion interrupt missing");

  no_intr_unreq_a: assert property (@(posedge sys_clk) disable iff (reset)
    (clkEn && state_q == S_DONE && !reqIntr_q) |=> !cmdDoneIntr_q)
    else $error("unrequested completion interrupt");

  dev_en_check_a: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(devEnabled_q) |-> $past(cmd_q) == AACU_CMD_ENABLE_DEV && $past(devConfigValid))
    else $error("device enabled without valid configuration");

  queue_en_dev_a: assert property (@(posedge sys_clk) disable iff (reset)
    (queueEnabled_q & ~$past(queueEnabled_q)) != '0 |-> $past(devEnabled_q) && $past(qCfgOk))
    else $error("queue enabled without device or valid configuration");

  sequence s_disable_done;
    clkEn && state_q == S_WAIT && cmd_q == AACU_CMD_DISABLE_DEV && !workPending;
  endsequence
  dev_disable_a: assert property (@(posedge sys_clk) disable iff (reset)
    s_disable_done |=> !devEnabled_q && queueEnabled_q == '0)
    else $error("disable device left something enabled");

  wait_idle_a: assert property (@(posedge sys_clk) disable iff (reset)
    (clkEn && state_q == S_WAIT && workPending) |=> state_q == S_WAIT)
    else $error("command left wait with work pending");

  active_flag_a: assert property (@(posedge sys_clk) disable iff (reset)
    (state_q != S_IDLE) |-> cmdActive_q)
    else $error("command active flag dropped early");

  take_active_a: assert property (@(posedge sys_clk) disable iff (reset)
    takeCmd |=> cmdActive_q && state_q != S_IDLE)
    else $error("command write not taken");

  wq_disable_a: assert property (@(posedge sys_clk) disable iff (reset)
    (waitDone && cmd_q == AACU_CMD_DISABLE_WQ) |=> (queueEnabled_q & mask_q) == '0)
    else $error("queue still enabled after disable");

  cap_gate_a: assert property (@(posedge sys_clk) disable iff (reset)
    (inExec && cmd_q == AACU_CMD_REQ_HANDLE && !handleReqCap) |=> result_q == ST_NO_CAP)
    else $error("handle request without capability not refused");

  intake_block_a: assert property (@(posedge sys_clk) disable iff (reset)
    (state_q == S_WAIT && cmd_q inside {AACU_CMD_DISABLE_DEV, AACU_CMD_RESET_DEV})
      |-> queueIntakeBlock_q == '1)
    else $error("device-wide intake not blocked while waiting");

  wq_block_a: assert property (@(posedge sys_clk) disable iff (reset)
    (state_q == S_WAIT && cmd_q inside {AACU_CMD_DISABLE_WQ, AACU_CMD_RESET_WQ})
      |-> (queueIntakeBlock_q & mask_q) == mask_q)
    else $error("named queue intake not blocked while waiting");

  abort_level_a: assert property (@(posedge sys_clk) disable iff (reset)
    (state_q == S_WAIT) |-> abortReq_q == isAbort(cmd_q))
    else $error("abort request level wrong while waiting");

  pasid_steer_a: assert property (@(posedge sys_clk) disable iff (reset)
    (state_q == S_WAIT && isPasidCmd) |-> pasidMatchEn_q && abortQueueMask_q == '0)
    else $error("address space steering missing while waiting");

  sequence s_wait_over;
    waitDone;
  endsequence
  wait_release_a: assert property (@(posedge sys_clk) disable iff (reset)
    s_wait_over |=> !abortReq_q && !pasidMatchEn_q && abortQueueMask_q == '0)
    else $error("abort steering left on after completion");

  dev_reset_a: assert property (@(posedge sys_clk) disable iff (reset)
    (waitDone && cmd_q == AACU_CMD_RESET_DEV) |=> devConfigReset_q && !devEnabled_q)
    else $error("device reset did not restore configuration");

  wq_reset_a: assert property (@(posedge sys_clk) disable iff (reset)
    (waitDone && cmd_q == AACU_CMD_RESET_WQ) |=> queueConfigReset_q == mask_q && qAllOff)
    else $error("queue reset did not clear named queues");

  no_handle_a: assert property (@(posedge sys_clk) disable iff (reset)
    (clkEn && state_q == S_HANDLE && !handleOk) |=> result_q == ST_NO_HANDLE)
    else $error("exhausted handle pool not reported");
endmodule : aacu_admin_cmd

/* File: sim/aacu_work_model.sv */
// Model of the descriptor work that the command unit waits on
`timescale 1ns/1ps
module aacu_work_model (
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic       loadWork,
  input  wire logic [7:0] loadMask,
  input  wire logic [7:0] loadLen,
  input  wire logic       abortReq_q,
  output logic [7:0]      queueBusy,
  output logic            enginesBusy,
  output logic            pasidBusy
);
  logic [7:0] cnt_q;
  logic [7:0] mask_q;

  // Work is only loaded with a command write, never while one runs
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cnt_q  <= 8'h00;
      mask_q <= 8'h00;
    end else if (loadWork) begin
      cnt_q  <= loadLen;
      mask_q <= loadMask;
    end else if (abortReq_q && cnt_q > 8'h02) begin
      cnt_q  <= 8'h02;
    end else if (cnt_q != 8'h00) begin
      cnt_q  <= cnt_q - 8'h01;
    end
  end

  assign queueBusy   = (cnt_q != 8'h00) ? mask_q : 8'h00;
  assign enginesBusy = (cnt_q != 8'h00);
  assign pasidBusy   = (cnt_q != 8'h00);
endmodule : aacu_work_model

/* File: sim/aacu_admin_cmd_test.sv */
// Self-checking bench of the admin command unit
`timescale 1ns/1ps
module aacu_admin_cmd_test;
  import aacu_pkg::*;
  logic sys_clk, reset, clkEn, cmdWrite, cmdReqIntr, devConfigValid, handleReqCap;
  logic [CMD_W-1:0] cmdCode;
  logic [7:0] cmdQueueMask, queueConfigValid, queueBusy, loadLen;
  logic [PASID_W-1:0] cmdPasid;
  logic enginesBusy, pasidBusy, loadWork;
  logic devEnabled_q, abortReq_q, pasidMatchEn_q, devConfigReset_q, cmdActive_q, cmdDoneIntr_q;
  logic [7:0] queueEnabled_q, queueIntakeBlock_q, abortQueueMask_q, queueConfigReset_q;
  logic [PASID_W-1:0] pasidMatch_q;
  logic [STATUS_W-1:0] cmdResult_q;
  logic [HANDLE_W-1:0] handle_q;
  int error_cnt, samples_checked, n;
  logic sawBlock, sawAbort, sawMask, sawPas, sawDevRst, sawQRst;

  aacu_admin_cmd aacu_admin_cmd_i (.sys_clk(sys_clk), .reset(reset), .clkEn(clkEn),
    .cmdWrite(cmdWrite), .cmdCode(cmdCode), .cmdQueueMask(cmdQueueMask), .cmdPasid(cmdPasid),
    .cmdReqIntr(cmdReqIntr), .devConfigValid(devConfigValid), .queueConfigValid(queueConfigValid),
    .handleReqCap(handleReqCap), .queueBusy(queueBusy), .enginesBusy(enginesBusy),
    .pasidBusy(pasidBusy), .devEnabled_q(devEnabled_q), .queueEnabled_q(queueEnabled_q),
    .queueIntakeBlock_q(queueIntakeBlock_q), .abortReq_q(abortReq_q),
    .abortQueueMask_q(abortQueueMask_q), .pasidMatchEn_q(pasidMatchEn_q),
    .pasidMatch_q(pasidMatch_q), .devConfigReset_q(devConfigReset_q),
    .queueConfigReset_q(queueConfigReset_q), .cmdActive_q(cmdActive_q),
    .cmdResult_q(cmdResult_q), .handle_q(handle_q), .cmdDoneIntr_q(cmdDoneIntr_q));

  aacu_work_model aacu_work_model_i (.sys_clk(sys_clk), .reset(reset), .loadWork(loadWork),
    .loadMask(cmdQueueMask), .loadLen(loadLen), .abortReq_q(abortReq_q), .queueBusy(queueBusy),
    .enginesBusy(enginesBusy), .pasidBusy(pasidBusy));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic results();
    if (error_cnt == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results

  task automatic chk(input logic [19:0] g, input logic [19:0] e);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  // One command write plus an ignored reset-device write at step 2; follow the first to completion and judge result and pulse
  task automatic run(input logic [4:0] c, input logic [7:0] m, input logic [19:0] p,
                     input logic ri, input logic [7:0] er, input logic [7:0] wl);
    logic ab;
    cmdCode = c; cmdQueueMask = m; cmdPasid = p; cmdReqIntr = ri;
    cmdWrite = 1'b1; loadLen = wl; loadWork = (wl != 8'h00);
    {sawBlock, sawAbort, sawMask, sawPas, sawDevRst, sawQRst} = 6'h00;
    @(posedge sys_clk); #10;
    cmdWrite = 1'b0; loadWork = 1'b0; n = 0;
    while (cmdActive_q === 1'b1 && n < 300) begin
      n++;
      if (n == 2) begin
        cmdWrite = 1'b1; cmdCode = AACU_CMD_RESET_DEV;
      end else cmdWrite = 1'b0;
      sawBlock  |= (queueIntakeBlock_q === m);
      sawAbort  |= (abortReq_q === 1'b1);
      sawMask   |= (abortQueueMask_q === m);
      sawPas    |= (pasidMatchEn_q === 1'b1 && pasidMatch_q === p);
      sawDevRst |= (devConfigReset_q === 1'b1);
      sawQRst   |= (queueConfigReset_q === m);
      @(posedge sys_clk); #10;
    end
    cmdWrite = 1'b0;
    chk(cmdResult_q, er);
    chk(cmdDoneIntr_q, ri);
    ab = c inside {AACU_CMD_ABORT_ALL, AACU_CMD_ABORT_WQ, AACU_CMD_ABORT_PAS,
                   AACU_CMD_RESET_DEV, AACU_CMD_RESET_WQ};
    // Drains run the whole load out; aborts cut the model's load to its last two steps
    if (wl != 8'h00) chk(n, ab ? 6 : wl + 2);
    chk({queueBusy, enginesBusy, pasidBusy}, 0);
  endtask : run

  task automatic t_reset_vals();
    chk({devEnabled_q, queueEnabled_q, cmdActive_q, cmdResult_q, cmdDoneIntr_q}, 0);
    chk({queueIntakeBlock_q, abortReq_q, abortQueueMask_q, pasidMatchEn_q, devConfigReset_q}, 0);
    chk({queueConfigReset_q, handle_q}, 0);
    chk(pasidMatch_q, 0);
  endtask : t_reset_vals

  task automatic t_clk_freeze();
    clkEn = 1'b0; cmdWrite = 1'b1; cmdCode = AACU_CMD_ENABLE_DEV;
    @(posedge sys_clk); #10;
    cmdWrite = 1'b0; clkEn = 1'b1;
    @(posedge sys_clk); #10;
    chk(cmdActive_q, 1'b0);
  endtask : t_clk_freeze

  task automatic t_enable();
    run(AACU_CMD_ENABLE_WQ, 8'h01, 0, 1'b0, ST_DEV_NOT_EN, 0);
    devConfigValid = 1'b0;
    run(AACU_CMD_ENABLE_DEV, 8'h00, 0, 1'b1, ST_DEV_CFG_ERR, 0);
    chk(devEnabled_q, 1'b0);
    devConfigValid = 1'b1;
    run(AACU_CMD_ENABLE_DEV, 8'h00, 0, 1'b1, ST_SUCCESS, 0);
    chk({devEnabled_q, n[3:0]}, {1'b1, 4'h2});
    queueConfigValid = 8'hfe;
    run(AACU_CMD_ENABLE_WQ, 8'h01, 0, 1'b0, ST_WQ_CFG_ERR, 0);
    chk(queueEnabled_q, 8'h00);
    queueConfigValid = 8'hff;
    run(AACU_CMD_ENABLE_WQ, 8'h05, 0, 1'b0, ST_SUCCESS, 0);
    chk(queueEnabled_q, 8'h05);
    run(5'h1f, 8'h00, 0, 1'b0, ST_BAD_CMD, 0);
  endtask : t_enable

  task automatic t_drain_abort();
    run(AACU_CMD_DRAIN_WQ, 8'h04, 0, 1'b1, ST_SUCCESS, 8'd20);
    chk(sawMask, 1'b1);
    chk(devEnabled_q, 1'b1);
    run(AACU_CMD_ABORT_WQ, 8'h01, 0, 1'b0, ST_SUCCESS, 8'd12);
    chk({sawAbort, sawMask}, 2'b11);
    run(AACU_CMD_DRAIN_ALL, 8'hff, 0, 1'b0, ST_SUCCESS, 8'd15);
    run(AACU_CMD_ABORT_ALL, 8'hff, 0, 1'b1, ST_SUCCESS, 8'd10);
    chk(sawAbort, 1'b1);
    run(AACU_CMD_DRAIN_PAS, 8'h00, 20'h5a5a5, 1'b0, ST_SUCCESS, 8'd9);
    chk(sawPas, 1'b1);
    run(AACU_CMD_ABORT_PAS, 8'h00, 20'hfffff, 1'b1, ST_SUCCESS, 8'd14);
    chk({sawPas, sawAbort}, 2'b11);
  endtask : t_drain_abort

  task automatic t_handles();
    logic [255:0] seen;
    seen = '0;
    handleReqCap = 1'b0;
    run(AACU_CMD_REQ_HANDLE, 8'h00, 0, 1'b0, ST_NO_CAP, 0);
    handleReqCap = 1'b1;
    for (int i = 0; i < NUM_HANDLES; i++) begin
      run(AACU_CMD_REQ_HANDLE, 8'h00, 0, 1'b0, ST_SUCCESS, 0);
      chk({seen[handle_q], n[3:0]}, {1'b0, 4'h3});
      seen[handle_q] = 1'b1;
    end
    run(AACU_CMD_REQ_HANDLE, 8'h00, 0, 1'b1, ST_NO_HANDLE, 0);
  endtask : t_handles

  task automatic t_disable_reset();
    run(AACU_CMD_DISABLE_WQ, 8'h04, 0, 1'b0, ST_SUCCESS, 8'd8);
    chk({sawBlock, queueEnabled_q}, {1'b1, 8'h01});
    run(AACU_CMD_RESET_WQ, 8'h01, 0, 1'b0, ST_SUCCESS, 8'd6);
    chk({sawQRst, queueEnabled_q}, {1'b1, 8'h00});
    run(AACU_CMD_ENABLE_WQ, 8'h03, 0, 1'b0, ST_SUCCESS, 0);
    run(AACU_CMD_RESET_DEV, 8'hff, 0, 1'b1, ST_SUCCESS, 8'd7);
    chk({sawDevRst, devEnabled_q, queueEnabled_q}, {2'b10, 8'h00});
    run(AACU_CMD_ENABLE_WQ, 8'h01, 0, 1'b0, ST_DEV_NOT_EN, 0);
    run(AACU_CMD_ENABLE_DEV, 8'h00, 0, 1'b0, ST_SUCCESS, 0);
    run(AACU_CMD_ENABLE_WQ, 8'h02, 0, 1'b0, ST_SUCCESS, 0);
    run(AACU_CMD_DISABLE_DEV, 8'hff, 0, 1'b1, ST_SUCCESS, 8'd11);
    chk({devEnabled_q, queueEnabled_q}, 9'h000);
  endtask : t_disable_reset

  initial begin
    #500000;
    error_cnt++;
    results();
  end

  initial begin
    error_cnt = 0; samples_checked = 0;
    reset = 1'b1; clkEn = 1'b1; cmdWrite = 1'b0; cmdCode = '0; cmdQueueMask = '0;
    cmdPasid = '0; cmdReqIntr = 1'b0; devConfigValid = 1'b1; queueConfigValid = 8'hff;
    handleReqCap = 1'b1; loadWork = 1'b0; loadLen = 8'h00;
    repeat (4) @(posedge sys_clk);
    #10;
    t_reset_vals();
    reset = 1'b0;
    t_clk_freeze();
    t_enable();
    t_drain_abort();
    t_handles();
    t_disable_reset();
    results();
  end
endmodule : aacu_admin_cmd_test
